// >>> logic/timer8_pkg.sv
// shared constants and types for the 8-bit timer waveform block
// assumes an AHB-Lite master with word-aligned single transfers
package timer8_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_A   = 8'h30;
  localparam logic [7:0] OFS_CTRL_B   = 8'h33;
  localparam logic [7:0] OFS_COUNT    = 8'h34;
  localparam logic [7:0] OFS_CMP_A    = 8'h38;
  localparam logic [7:0] OFS_CMP_B    = 8'h3c;
  localparam logic [7:0] OFS_FLAGS    = 8'h40;
  localparam logic [7:0] OFS_PORT     = 8'h44;
  // field positions
  localparam int POS_MODE_A   = 6;
  localparam int POS_MODE_B   = 4;
  localparam int POS_TOP_BIT  = 3;
  localparam int POS_TICK_EN  = 0;
  localparam int POS_OVF      = 0;
  localparam int POS_FLAG_A   = 1;
  localparam int POS_FLAG_B   = 2;
  localparam int POS_DIR_A    = 0;
  localparam int POS_DIR_B    = 1;
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h09;
  localparam logic [7:0] RESET_VAL   = 8'h00;
  localparam logic [7:0] MAX_VAL     = 8'hff;
  localparam logic [7:0] BOTTOM_VAL  = 8'h00;
  localparam logic [3:0] TICK_DIV    = 4'h8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    WM_NORMAL   = 3'h0,
    WM_PC_FF    = 3'h1,
    WM_CTC      = 3'h2,
    WM_FAST_FF  = 3'h3,
    WM_RSV4     = 3'h4,
    WM_PC_CMP   = 3'h5,
    WM_RSV6     = 3'h6,
    WM_FAST_CMP = 3'h7
  } wave_mode_t;

  typedef struct packed {
    logic [1:0] out_mode;
    logic       top_bit;
    logic       is_chan_a;
    logic       fast;
    logic       phase;
    logic       match;
    logic       at_top;
    logic       at_bottom;
    logic       up;
    logic       cmp_is_top;
    logic       tick;
  } wave_ctl_t;
endpackage : timer8_pkg

// >>> logic/wave_channel.sv
// one compare output waveform generator
// assumes strobes come from the counter on the same clock
`timescale 1ns/1ps
`default_nettype none
module wave_channel
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // control from the counter
  input  wire wave_ctl_t ctl,
  // waveform
  output logic           wave_r
);
  logic wave_nxt;

  always_comb begin
    wave_nxt = wave_r;
    if (ctl.tick) begin
      if (ctl.fast) begin
        if (ctl.match && !(ctl.cmp_is_top && ctl.out_mode[1])) begin
          unique case (ctl.out_mode)
            2'h1: if (ctl.is_chan_a && ctl.top_bit) wave_nxt = ~wave_r;
            2'h2: wave_nxt = 1'b0;
            2'h3: wave_nxt = 1'b1;
            default: wave_nxt = wave_r;
          endcase
        end else if (ctl.at_bottom && ctl.out_mode[1]) begin
          wave_nxt = ~ctl.out_mode[0];
        end
      end else if (ctl.phase) begin
        if (ctl.cmp_is_top && ctl.out_mode[1]) begin
          // action at top instead
          // non-inverting sits high, like a down-count match
          if (ctl.at_top) wave_nxt = ~ctl.out_mode[0];
        end else if (ctl.match) begin
          unique case (ctl.out_mode)
            2'h1: if (ctl.is_chan_a && ctl.top_bit) wave_nxt = ~wave_r;
            2'h2: wave_nxt = ~ctl.up;
            2'h3: wave_nxt = ctl.up;
            default: wave_nxt = wave_r;
          endcase
        end
      end else if (ctl.match) begin
        unique case (ctl.out_mode)
          2'h1: wave_nxt = ~wave_r;
          2'h2: wave_nxt = 1'b0;
          2'h3: wave_nxt = 1'b1;
          default: wave_nxt = wave_r;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wave_r <= 1'b0;
    else wave_r <= wave_nxt;
  end

  AST_NONPWM_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.tick && ctl.match && !ctl.fast && !ctl.phase &&
     ctl.out_mode == 2'h3) |=> wave_r)
    else $error("set on match failed");
  // clear on match in fast pwm
  AST_FAST_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.tick && ctl.match && ctl.fast && !ctl.cmp_is_top &&
     ctl.out_mode == 2'h2) |=> !wave_r)
    else $error("fast clear on match failed");
  AST_PC_UP_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.tick && ctl.match && ctl.phase && ctl.up && !ctl.cmp_is_top &&
     ctl.out_mode == 2'h2) |=> !wave_r)
    else $error("phase up clear failed");
  AST_PC_TOP: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl.tick && ctl.phase && ctl.cmp_is_top && ctl.at_top &&
     ctl.out_mode == 2'h3) |=> !wave_r)
    else $error("phase top action failed");
endmodule : wave_channel
`default_nettype wire

// >>> logic/timer8_wave.sv
// 8-bit timer with waveform modes and two compare outputs
// assumes one ahb-lite master; pins resolved by the port logic outside
//
// Overview of operation
// - synchronous; tick enable gates counting
// - channel a drives pin when mode nonzero
// - non-pwm a: off, toggle, clear, set
// - fast pwm a: match and bottom actions
// - fast pwm ignores match at top, except the toggle on a
// - phase pwm a: slope dependent actions
// - phase pwm top match acts at top
// - channel b drives pin when mode nonzero
// - non-pwm b: off, toggle, clear, set
// - fast pwm b: 01 reserved, others
// - phase pwm b: 01 reserved, slopes
// - control a bits 3:2 read zero
// - mode code selects counting sequence
// - top is ff or compare a
// - compare update immediate, top, bottom
// - overflow flag point per mode
// - match flags and ctc clear
// - max ff, bottom zero fixed
// - top mode bit in control b
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module timer8_wave
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        port_a_data,
  input  wire logic        port_b_data,
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n
);
  logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt;
  logic [7:0] cnt_r, cnt_nxt, cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt;
  logic [7:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
  logic [2:0] flags_r, flags_nxt;
  logic [1:0] dir_r, dir_nxt;
  logic       down_r, down_nxt, cnt_wr_r, cnt_wr_nxt;
  logic [3:0] div_r, div_nxt;
  logic       wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_ofs_r, wr_ofs_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       tick, addr_ok;
  logic [7:0] top, wdat;
  logic       fast, phase, ctc_like, imm_upd;
  logic       at_top, at_max, at_bottom, m_a, m_b, ovf_ev, flag_clr;
  wave_mode_t mode;
  wave_ctl_t  ctl_a, ctl_b;
  logic       wave_a, wave_b;

  assign mode  = wave_mode_t'({ctrl_b_r[POS_TOP_BIT], ctrl_a_r[1:0]});
  assign fast  = (mode == WM_FAST_FF) || (mode == WM_FAST_CMP);
  assign phase = (mode == WM_PC_FF) || (mode == WM_PC_CMP);
  assign top = (mode == WM_CTC || mode == WM_PC_CMP || mode == WM_FAST_CMP)
               ? cmp_a_r : MAX_VAL;
  assign ctc_like = (mode == WM_CTC) || (mode == WM_FAST_CMP);
  assign at_max    = cnt_r == MAX_VAL;
  assign at_bottom = cnt_r == BOTTOM_VAL;
  assign at_top    = cnt_r == top;
  assign imm_upd = (mode == WM_NORMAL) || (mode == WM_CTC);
  // write to the counter blocks the next match
  assign m_a = (cnt_r == cmp_a_r) && !cnt_wr_r;
  assign m_b = (cnt_r == cmp_b_r) && !cnt_wr_r;

  always_comb begin
    div_nxt = div_r;
    tick    = 1'b0;
    if (ctrl_b_r[POS_TICK_EN]) begin
      if (div_r == TICK_DIV - 4'h1) begin
        div_nxt = 4'h0;
        tick    = 1'b1;
      end else begin
        div_nxt = div_r + 4'h1;
      end
    end
  end

  always_comb begin
    unique case (mode)
      WM_PC_FF, WM_PC_CMP: ovf_ev = at_bottom && down_r;
      WM_FAST_CMP:         ovf_ev = at_top;
      default:             ovf_ev = at_max;
    endcase
  end

  assign addr_ok = (wr_ofs_r == OFS_CTRL_A) || (wr_ofs_r == OFS_CTRL_B) ||
                   (wr_ofs_r == OFS_COUNT) || (wr_ofs_r == OFS_CMP_A) ||
                   (wr_ofs_r == OFS_CMP_B) || (wr_ofs_r == OFS_FLAGS) ||
                   (wr_ofs_r == OFS_PORT);
  assign wdat = hwdata[7:0];
  assign flag_clr = wr_pend_r && (wr_ofs_r == OFS_FLAGS);

  always_comb begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    cnt_nxt    = cnt_r;
    cmp_a_nxt  = cmp_a_r;
    cmp_b_nxt  = cmp_b_r;
    buf_a_nxt  = buf_a_r;
    buf_b_nxt  = buf_b_r;
    flags_nxt  = flags_r;
    dir_nxt    = dir_r;
    down_nxt   = down_r;
    cnt_wr_nxt = cnt_wr_r;
    if (tick) begin
      cnt_wr_nxt = 1'b0;
      if (phase) begin
        if (at_top) begin
          down_nxt = 1'b1;
          cnt_nxt  = cnt_r - 8'h1;
        end else if (at_bottom) begin
          down_nxt = 1'b0;
          cnt_nxt  = cnt_r + 8'h1;
        end else begin
          cnt_nxt = down_r ? cnt_r - 8'h1 : cnt_r + 8'h1;
        end
      end else if (ctc_like && m_a) begin
        cnt_nxt = BOTTOM_VAL;
      end else if (fast && at_top) begin
        cnt_nxt = BOTTOM_VAL;
      end else begin
        cnt_nxt = cnt_r + 8'h1;
      end
      if ((phase && at_top) || (fast && cnt_nxt == BOTTOM_VAL)) begin
        cmp_a_nxt = buf_a_r;
        cmp_b_nxt = buf_b_r;
      end
    end
    // software clears by writing one, events set afterwards win
    if (flag_clr) flags_nxt = flags_r & ~wdat[2:0];
    if (tick) begin
      if (ovf_ev) flags_nxt[POS_OVF] = 1'b1;
      if (m_a) flags_nxt[POS_FLAG_A] = 1'b1;
      if (m_b) flags_nxt[POS_FLAG_B] = 1'b1;
    end
    if (wr_pend_r && addr_ok) begin
      unique case (wr_ofs_r)
        OFS_CTRL_A: ctrl_a_nxt = wdat & CTRL_A_MASK;
        OFS_CTRL_B: ctrl_b_nxt = wdat & CTRL_B_MASK;
        OFS_COUNT: begin
          cnt_nxt    = wdat;
          cnt_wr_nxt = 1'b1;
        end
        OFS_CMP_A: begin
          buf_a_nxt = wdat;
          if (imm_upd) cmp_a_nxt = wdat;
        end
        OFS_CMP_B: begin
          buf_b_nxt = wdat;
          if (imm_upd) cmp_b_nxt = wdat;
        end
        OFS_PORT: dir_nxt = wdat[1:0];
        default: ;
      endcase
    end
  end

  // ahb-lite: zero wait states, writes land in the data phase
  always_comb begin
    wr_pend_nxt = 1'b0;
    wr_ofs_nxt  = wr_ofs_r;
    rdata_nxt   = rdata_r;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      wr_ofs_nxt  = haddr[7:0];
      wr_pend_nxt = hwrite;
      unique case (haddr[7:0])
        OFS_CTRL_A: rdata_nxt = ctrl_a_r & CTRL_A_MASK;
        OFS_CTRL_B: rdata_nxt = ctrl_b_r;
        OFS_COUNT:  rdata_nxt = cnt_r;
        OFS_CMP_A:  rdata_nxt = imm_upd ? cmp_a_r : buf_a_r;
        OFS_CMP_B:  rdata_nxt = imm_upd ? cmp_b_r : buf_b_r;
        OFS_FLAGS:  rdata_nxt = {5'h00, flags_r};
        OFS_PORT:   rdata_nxt = {6'h00, dir_r};
        default:    rdata_nxt = RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_r  <= RESET_VAL;
      ctrl_b_r  <= RESET_VAL;
      cnt_r     <= RESET_VAL;
      cmp_a_r   <= RESET_VAL;
      cmp_b_r   <= RESET_VAL;
      buf_a_r   <= RESET_VAL;
      buf_b_r   <= RESET_VAL;
      flags_r   <= 3'h0;
      dir_r     <= 2'h0;
      down_r    <= 1'b0;
      cnt_wr_r  <= 1'b0;
      div_r     <= 4'h0;
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= RESET_VAL;
      rdata_r   <= RESET_VAL;
    end else begin
      ctrl_a_r  <= ctrl_a_nxt;
      ctrl_b_r  <= ctrl_b_nxt;
      cnt_r     <= cnt_nxt;
      cmp_a_r   <= cmp_a_nxt;
      cmp_b_r   <= cmp_b_nxt;
      buf_a_r   <= buf_a_nxt;
      buf_b_r   <= buf_b_nxt;
      flags_r   <= flags_nxt;
      dir_r     <= dir_nxt;
      down_r    <= down_nxt;
      cnt_wr_r  <= cnt_wr_nxt;
      div_r     <= div_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_ofs_r  <= wr_ofs_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign hrdata    = {24'h000000, rdata_r};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    ctl_a = '0;
    ctl_a.out_mode   = ctrl_a_r[POS_MODE_A +: 2];
    ctl_a.top_bit    = ctrl_b_r[POS_TOP_BIT];
    ctl_a.is_chan_a  = 1'b1;
    ctl_a.fast       = fast;
    ctl_a.phase      = phase;
    ctl_a.match      = m_a;
    ctl_a.at_top     = at_top;
    // bottom action lands on the tick the counter wraps to zero
    ctl_a.at_bottom  = at_top || at_max;
    ctl_a.up         = !down_r;
    ctl_a.cmp_is_top = cmp_a_r == top;
    ctl_a.tick       = tick;
    ctl_b = ctl_a;
    ctl_b.out_mode   = ctrl_a_r[POS_MODE_B +: 2];
    ctl_b.is_chan_a  = 1'b0;
    ctl_b.match      = m_b;
    ctl_b.cmp_is_top = cmp_b_r == top;
  end

  wave_channel u_chan_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl     (ctl_a),
    .wave_r  (wave_a)
  );
  wave_channel u_chan_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl     (ctl_b),
    .wave_r  (wave_b)
  );

  assign pin_a_out  = (ctrl_a_r[POS_MODE_A +: 2] != 2'h0) ? wave_a
                                                          : port_a_data;
  assign pin_b_out  = (ctrl_a_r[POS_MODE_B +: 2] != 2'h0) ? wave_b
                                                          : port_b_data;
  assign pin_a_oe_n = !dir_r[POS_DIR_A];
  assign pin_b_oe_n = !dir_r[POS_DIR_B];

  AST_CTC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && ctc_like && m_a && !wr_pend_r) |=> cnt_r == BOTTOM_VAL)
    else $error("counter not cleared on match");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (!tick && !wr_pend_r) |=> $stable(cnt_r))
    else $error("counter moved without tick");
  AST_OVF: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && mode == WM_NORMAL && at_max) |=> flags_r[POS_OVF])
    else $error("overflow flag missing");
  AST_RSV: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_a_r[3:2] == 2'h0)
    else $error("reserved bits set");
  AST_PIN_A: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_a_r[7:6] != 2'h0) |-> pin_a_out == wave_a)
    else $error("pin a not overridden");
  // fast pwm holds compare mid period
  AST_BUF: assert property (@(posedge hclk) disable iff (!hresetn)
    (fast && tick && !at_top && !at_max && !(ctc_like && m_a) &&
     !wr_pend_r)
    |=> $stable(cmp_a_r))
    else $error("compare updated mid period");
  COV_CTC: cover property (@(posedge hclk) tick && mode == WM_CTC && m_a);
  COV_FAST: cover property (@(posedge hclk) tick && fast && at_top);
  COV_PC: cover property (@(posedge hclk) tick && phase && at_bottom);
endmodule : timer8_wave
`default_nettype wire

// >>> tb/timer8_wave_tb.sv
// self-checking bench for the 8-bit timer waveform block
// assumes the design answers ahb-lite with zero wait states
`timescale 1ns/1ps
`default_nettype none
module timer8_wave_tb
  import timer8_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        port_a_data;
  logic        port_b_data;
  logic        pin_a_out;
  logic        pin_a_oe_n;
  logic        pin_b_out;
  logic        pin_b_oe_n;
  int          n_mismatch;
  int          n_tests;
  logic [7:0]  v;
  logic        pa;
  logic        pb;
  logic        inv;

  assign hready = hreadyout;

  timer8_wave dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .port_a_data(port_a_data),
    .port_b_data(port_b_data), .pin_a_out(pin_a_out),
    .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out),
    .pin_b_oe_n(pin_b_oe_n)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait so a stuck slave cannot hang the bus task
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100) chk("hready", 8'h01, 8'h00);
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [7:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(1'b0, a, 8'h00, d);
  endtask

  // polls until the flag sets, then clears it by writing one
  task automatic wait_flag(input int pos);
    logic [7:0] f;
    int n;
    n = 0;
    rd(OFS_FLAGS, f);
    while (f[pos] !== 1'b1 && n < 3000) begin
      rd(OFS_FLAGS, f);
      n++;
    end
    if (n >= 3000) chk("flag wait", 8'h01, 8'h00);
    wr(OFS_FLAGS, 8'h01 << pos);
  endtask

  // windows keep clear of match edges so latency does not matter
  task automatic pwm_win(input logic [7:0] lo, input logic [7:0] hi,
                         input logic ea, input logic eb);
    logic [7:0] c;
    int n;
    n = 0;
    rd(OFS_COUNT, c);
    while (!(c >= lo && c <= hi) && n < 3000) begin
      rd(OFS_COUNT, c);
      n++;
    end
    if (n >= 3000) chk("count wait", 8'h01, 8'h00);
    chk("pwm pin a", {7'h00, ea}, {7'h00, pin_a_out});
    chk("pwm pin b", {7'h00, eb}, {7'h00, pin_b_out});
  endtask

  initial begin
    repeat (80000) @(posedge hclk);
    n_mismatch++;
    $display("unexpected watchdog expected done seen hang");
    wrap_up();
  end

  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    port_a_data = 1'b0;
    port_b_data = 1'b0;
    hresetn = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFS_CTRL_A, v);
    chk("ctrl a reset", RESET_VAL, v);
    chk("oe a reset", 8'h01, {7'h00, pin_a_oe_n});
    wr(OFS_CTRL_A, 8'hff);
    rd(OFS_CTRL_A, v);
    chk("ctrl a reserved", CTRL_A_MASK, v);
    wr(OFS_CTRL_A, 8'h00);
    rd(8'h50, v);
    chk("unmapped", 8'h00, v);
    $display("test registers done");

    port_a_data <= 1'b1;
    wr(OFS_PORT, 8'h01);
    // write lands at the data-phase edge, look one cycle later
    @(posedge hclk);
    chk("oe a", 8'h00, {7'h00, pin_a_oe_n});
    chk("oe b", 8'h01, {7'h00, pin_b_oe_n});
    chk("port a", 8'h01, {7'h00, pin_a_out});
    chk("port b", 8'h00, {7'h00, pin_b_out});
    $display("test pins done");

    wr(OFS_COUNT, 8'h10);
    repeat (64) @(posedge hclk);
    rd(OFS_COUNT, v);
    chk("count held", 8'h10, v);
    wr(OFS_CTRL_B, 8'h01);
    repeat (64) @(posedge hclk);
    rd(OFS_COUNT, v);
    chk("count ran", 8'h01, {7'h00, v >= 8'h16 && v <= 8'h1a});
    $display("test tick done");

    wr(OFS_CMP_A, 8'h0f);
    wr(OFS_CMP_B, 8'h08);
    wr(OFS_COUNT, 8'h00);
    for (int c = 3; c >= 0; c--) begin
      wr(OFS_CTRL_A, {c[1:0], c[1:0], 4'h2});
      wr(OFS_FLAGS, 8'h07);
      wait_flag(POS_FLAG_A);
      rd(OFS_COUNT, v);
      chk("ctc count", 8'h01, {7'h00, v <= 8'h0f});
      wait_flag(POS_FLAG_B);
      pa = pin_a_out;
      pb = pin_b_out;
      if (c == 1) begin
        wait_flag(POS_FLAG_A);
        chk("toggle a", {7'h00, ~pa}, {7'h00, pin_a_out});
        wait_flag(POS_FLAG_B);
        chk("toggle b", {7'h00, ~pb}, {7'h00, pin_b_out});
      end else begin
        chk("ctc a", {7'h00, c == 0 ? 1'b1 : c[0]}, {7'h00, pa});
        chk("ctc b", {7'h00, c == 0 ? 1'b0 : c[0]}, {7'h00, pb});
      end
    end
    $display("test clear on match done");

    wr(OFS_CMP_A, 8'h80);
    wr(OFS_CMP_B, 8'h40);
    // m bit0 picks inverting, bit1 picks phase correct
    for (int m = 0; m < 4; m++) begin
      inv = m[0];
      wr(OFS_CTRL_A, {1'b1, inv, 1'b1, inv, 2'h0, m[1] ? 2'h1 : 2'h3});
      wr(OFS_COUNT, 8'h00);
      pwm_win(8'h82, 8'hfd, inv, inv);
      pwm_win(8'h02, 8'h3e, ~inv, ~inv);
      pwm_win(8'h42, 8'h7e, ~inv, inv);
    end
    $display("test pwm done");

    wr(OFS_CTRL_A, 8'h02);
    wr(OFS_CMP_A, 8'h20);
    wr(OFS_COUNT, 8'h00);
    // low bits leave ctc before top bit, no reserved code
    wr(OFS_CTRL_A, 8'h83);
    wr(OFS_CTRL_B, 8'h09);
    wr(OFS_FLAGS, 8'h07);
    wait_flag(POS_OVF);
    wait_flag(POS_FLAG_A);
    pwm_win(8'h02, 8'h1e, 1'b1, port_b_data);
    for (int i = 0; i < 16; i++) begin
      rd(OFS_COUNT, v);
      chk("top count", 8'h01, {7'h00, v <= 8'h20});
      chk("top pin a", 8'h01, {7'h00, pin_a_out});
    end
    // mode 5 inverting: compare a is top, level taken at top
    wr(OFS_CTRL_A, 8'hc1);
    wr(OFS_FLAGS, 8'h07);
    // two bottoms in a row guarantee one pass through top
    wait_flag(POS_OVF);
    wait_flag(POS_OVF);
    for (int i = 0; i < 8; i++) begin
      rd(OFS_COUNT, v);
      chk("pc top count", 8'h01, {7'h00, v <= 8'h20});
      chk("pc top pin a", 8'h00, {7'h00, pin_a_out});
    end
    chk("hresp", 8'h00, {7'h00, hresp});
    $display("test compare top done");
    wrap_up();
  end
endmodule // timer8_wave_tb
`default_nettype wire
